/* rtl/clb_pkg.sv */
// What this block does
// - 24 digital and 6 analog flags
// - Flags show previous cycle value, held
// - Startup flag high while stopped and in first cycle
// - Startup flag then acts as ordinary flag
// - Shift bits readable, never written here
// - 16 blank outputs, sink only
// - Up to 16 digital outputs, base first
// - Digital inputs numbered base then modules
// - Inputs 7 and 8 may be analog
// - Two analog outputs, analog sinks and sources
// - Four cursor keys act as inputs
// - Any input may be constant 1 or 0
// - Each gate input individually invertible
// - AND: 1 when all inputs 1
// - Edge AND: all 1, one was 0
// - NAND: 0 when all inputs 1
package clb_pkg;

  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int CLB_CLK_NS = 4;
  localparam int CLB_CYCLE_NS = 1000;
  localparam int CLB_CYCLE_CLKS = (CLB_CYCLE_NS + CLB_CLK_NS - 1) / CLB_CLK_NS;
  localparam int CLB_NDIN = 16;
  localparam int CLB_NDOUT = 16;
  localparam int CLB_NBLANK = 16;
  localparam int CLB_NFLAG = 24;
  localparam int CLB_NAFLAG = 6;
  localparam int CLB_NAQ = 2;
  localparam int CLB_NSHIFT = 8;
  localparam int CLB_NCURSOR = 4;
  localparam int CLB_NAIN = 8;
  localparam int CLB_NGATE = 8;
  localparam int CLB_AW = 10;
  localparam logic [CLB_NFLAG-1:0] CLB_FLAG_RST = 24'h000080;
  localparam logic [CLB_NDIN-1:0] CLB_DUAL_MASK = 16'h00C0;

  // ----------------------------------------------------------------
  // Digital source codes (6 bit) and analog source codes (4 bit)
  // ----------------------------------------------------------------
  localparam logic [5:0] CLB_SRC_LO = 6'h00;
  localparam logic [5:0] CLB_SRC_HI = 6'h01;
  localparam logic [5:0] CLB_SRC_DIN = 6'h02;
  localparam logic [5:0] CLB_SRC_FLAG = 6'h12;
  localparam logic [5:0] CLB_SRC_SHIFT = 6'h2A;
  localparam logic [5:0] CLB_SRC_CURSOR = 6'h32;
  localparam logic [5:0] CLB_SRC_GATE = 6'h36;
  localparam logic [5:0] CLB_SRC_OPEN = 6'h3F;
  localparam logic [3:0] CLB_ASRC_AIN = 4'h0;
  localparam logic [3:0] CLB_ASRC_AFLAG = 4'h8;
  localparam logic [3:0] CLB_ASRC_AQ = 4'hE;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CLB_REG_CTRL = 8'h00;
  localparam logic [7:0] CLB_REG_STATUS = 8'h04;
  localparam logic [7:0] CLB_REG_CURSOR = 8'h08;
  localparam logic [7:0] CLB_REG_FLAGS = 8'h0C;
  localparam logic [7:0] CLB_REG_OUTS = 8'h10;
  localparam logic [7:0] CLB_REG_GATES = 8'h14;
  localparam logic [7:0] CLB_REG_CFG = 8'h20;
  localparam int CLB_NCFG = 24;
  localparam int CLB_CFG_GATE = 0;
  localparam int CLB_CFG_OUT = 8;
  localparam int CLB_CFG_BLANK = 12;
  localparam int CLB_CFG_FLAG = 16;
  localparam int CLB_CFG_ANA = 22;
  localparam int CLB_GCFG_INV = 24;
  localparam int CLB_GCFG_TYPE = 28;
  localparam logic [31:0] CLB_GCFG_RST = 32'h00FFFFFF;
  localparam int CLB_CTRL_RUN = 0;
  localparam int CLB_CTRL_DUAL = 1;
  localparam logic [1:0] CLB_RESP_OKAY = 2'h0;
  localparam logic [1:0] CLB_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [CLB_AW-1:0] clb_ana_t;
  typedef enum logic [1:0] {
    CLB_GATE_AND = 2'h0,
    CLB_GATE_EDGE_AND = 2'h1,
    CLB_GATE_NAND = 2'h3
  } clb_gate_t;
  typedef enum logic [1:0] {
    CLB_ST_STOP = 2'h0,
    CLB_ST_FIRST = 2'h1,
    CLB_ST_RUN = 2'h3
  } clb_state_t;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } clb_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } clb_axi_rsp_t;

endpackage

/* rtl/clb_top.sv */
`timescale 1ns/1ps
module clb_top #(
  parameter int CYCLE_CLKS = clb_pkg::CLB_CYCLE_CLKS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire clb_pkg::clb_axi_req_t i_axi,
  output clb_pkg::clb_axi_rsp_t o_axi,
  input wire logic [clb_pkg::CLB_NDIN-1:0] i_din,
  input wire logic [clb_pkg::CLB_NSHIFT-1:0] i_shift,
  input wire clb_pkg::clb_ana_t [clb_pkg::CLB_NAIN-1:0] i_ain,
  output logic [clb_pkg::CLB_NDOUT-1:0] o_dout,
  output clb_pkg::clb_ana_t [clb_pkg::CLB_NAQ-1:0] o_aq,
  output logic o_startup
);
  import clb_pkg::*;

  localparam int CW = (CYCLE_CLKS > 1) ? $clog2(CYCLE_CLKS) : 1;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] ctrl_reg;
  logic [CLB_NCURSOR-1:0] cursor_reg;
  logic [CLB_NCFG-1:0][31:0] cfg_reg;
  clb_state_t state_reg;
  clb_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic tick;
  logic [CLB_NDIN-1:0] din_s1, din_s2, din_eff;
  logic [CLB_NSHIFT-1:0] shf_s1, shf_s2;
  clb_ana_t [CLB_NAIN-1:0] ain_s1, ain_s2, ain_eff;
  logic [CLB_NFLAG-1:0] flag_reg, flag_next;
  logic [CLB_NGATE-1:0] gate_reg, gate_next;
  logic [CLB_NGATE-1:0][3:0] prev_reg, vin_next;
  logic [CLB_NDOUT-1:0] dout_reg, dout_next;
  logic [CLB_NBLANK-1:0] blank_reg, blank_next;
  clb_ana_t [CLB_NAFLAG-1:0] aflag_reg, aflag_next;
  clb_ana_t [CLB_NAQ-1:0] aq_reg, aq_next;
  logic [63:0] pool;
  clb_ana_t [15:0] apool;
  logic aw_have, w_have, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rdata_reg;
  logic [3:0] w_strb;
  logic [1:0] bresp_reg, rresp_reg;
  logic do_wr, wr_hit, wr_cfg, rd_take, rd_hit, rd_cfg;
  logic [4:0] wr_idx, rd_idx;
  logic [31:0] rd_word;

  // Select one digital source, an open terminal reads 0
  function automatic logic pick(input logic [63:0] p, input logic [5:0] s);
    pick = (s == CLB_SRC_OPEN) ? 1'b0 : p[s];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages on every field input
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      din_s1 <= '0;
      din_s2 <= '0;
      shf_s1 <= '0;
      shf_s2 <= '0;
      ain_s1 <= '0;
      ain_s2 <= '0;
    end else begin
      din_s1 <= i_din;
      din_s2 <= din_s1;
      shf_s1 <= i_shift;
      shf_s2 <= shf_s1;
      ain_s1 <= i_ain;
      ain_s2 <= ain_s1;
    end
  end

  // ----------------------------------------------------------------
  // Source pools
  // ----------------------------------------------------------------
  // Dual-use pins read 0 digitally while in analog use
  assign din_eff = ctrl_reg[CLB_CTRL_DUAL] ?
                   (din_s2 & ~CLB_DUAL_MASK) : din_s2;
  assign ain_eff[0] = ctrl_reg[CLB_CTRL_DUAL] ? ain_s2[0] : '0;
  assign ain_eff[1] = ctrl_reg[CLB_CTRL_DUAL] ? ain_s2[1] : '0;
  assign ain_eff[CLB_NAIN-1:2] = ain_s2[CLB_NAIN-1:2];

  // Digital pool: constants, inputs, flags, shift bits, keys, gates
  assign pool = {2'h0, gate_reg, cursor_reg, shf_s2, flag_reg,
                 din_eff, 1'b1, 1'b0};

  // Analog pool: inputs, analog flags, analog outputs
  assign apool = {aq_reg, aflag_reg, ain_eff};

  // ----------------------------------------------------------------
  // Basic gates
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CLB_NGATE; g++) begin : g_gate
    logic [31:0] c;
    logic [3:0] v;
    logic all_one;
    clb_gate_t gtype;
    assign c = cfg_reg[CLB_CFG_GATE+g];
    assign gtype = clb_gate_t'(c[CLB_GCFG_TYPE +: 2]);
    for (genvar k = 0; k < 4; k++) begin : g_in
      logic [5:0] s;
      assign s = c[6*k +: 6];
      // Open input counts as 1, otherwise optional inversion
      assign v[k] = (s == CLB_SRC_OPEN) ? 1'b1 :
                    (pool[s] ^ c[CLB_GCFG_INV+k]);
    end
    assign all_one = &v;
    assign vin_next[g] = v;
    // Gate function by type
    assign gate_next[g] =
      (gtype == CLB_GATE_NAND) ? ~all_one :
      (gtype == CLB_GATE_EDGE_AND) ?
        (all_one & ~(&prev_reg[g])) :
      all_one;
  end

  // ----------------------------------------------------------------
  // Terminals
  // ----------------------------------------------------------------
  for (genvar i = 0; i < CLB_NDOUT; i++) begin : g_out
    assign dout_next[i] =
      pick(pool, cfg_reg[CLB_CFG_OUT+i/4][8*(i%4) +: 6]);
  end

  for (genvar i = 0; i < CLB_NBLANK; i++) begin : g_blank
    assign blank_next[i] =
      pick(pool, cfg_reg[CLB_CFG_BLANK+i/4][8*(i%4) +: 6]);
  end

  for (genvar i = 0; i < CLB_NFLAG; i++) begin : g_flag
    assign flag_next[i] =
      pick(pool, cfg_reg[CLB_CFG_FLAG+i/4][8*(i%4) +: 6]);
  end

  for (genvar j = 0; j < CLB_NAFLAG; j++) begin : g_aflag
    assign aflag_next[j] =
      apool[cfg_reg[CLB_CFG_ANA][4*j +: 4]];
  end

  for (genvar j = 0; j < CLB_NAQ; j++) begin : g_aq
    assign aq_next[j] =
      apool[cfg_reg[CLB_CFG_ANA+1][4*j +: 4]];
  end

  // ----------------------------------------------------------------
  // Program cycle sequencing
  // ----------------------------------------------------------------
  // End of each program cycle
  assign tick = (state_reg != CLB_ST_STOP) &&
                (cnt_reg == CW'(CYCLE_CLKS - 1));

  // Run state: stopped, first cycle, running
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CLB_ST_STOP: begin
        if (ctrl_reg[CLB_CTRL_RUN]) begin
          state_next = CLB_ST_FIRST;
        end
      end
      CLB_ST_FIRST: begin
        if (!ctrl_reg[CLB_CTRL_RUN]) begin
          state_next = CLB_ST_STOP;
        end else if (tick) begin
          state_next = CLB_ST_RUN;
        end
      end
      CLB_ST_RUN: begin
        if (!ctrl_reg[CLB_CTRL_RUN]) begin
          state_next = CLB_ST_STOP;
        end
      end
      default: begin
        state_next = CLB_ST_STOP;
      end
    endcase
  end

  // State and cycle counter
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= CLB_ST_STOP;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (tick || state_reg == CLB_ST_STOP) ? '0 : cnt_reg + 1'b1;
    end
  end

  // Cycle results, all latched together at the cycle end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_reg <= CLB_FLAG_RST;
      gate_reg <= '0;
      prev_reg <= '1;
      dout_reg <= '0;
      blank_reg <= '0;
      aflag_reg <= '0;
      aq_reg <= '0;
    end else if (state_reg == CLB_ST_STOP) begin
      flag_reg <= CLB_FLAG_RST;
      gate_reg <= '0;
      prev_reg <= '1;
      dout_reg <= '0;
      blank_reg <= '0;
      aflag_reg <= '0;
      aq_reg <= '0;
    end else if (tick) begin
      flag_reg <= flag_next;
      gate_reg <= gate_next;
      prev_reg <= vin_next;
      dout_reg <= dout_next;
      blank_reg <= blank_next;
      aflag_reg <= aflag_next;
      aq_reg <= aq_next;
    end
  end

  assign o_dout = dout_reg;
  assign o_aq = aq_reg;
  assign o_startup = flag_reg[7];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Write decode once address and data are both held
  assign do_wr = aw_have && w_have && !bvalid_reg;
  assign wr_cfg = !aw_addr[7] && (aw_addr[6:5] != 2'h0);
  assign wr_idx = aw_addr[6:2] - 5'd8;
  assign wr_hit = wr_cfg || (aw_addr[1:0] == 2'h0 &&
                  aw_addr <= CLB_REG_GATES);

  // Read decode on the address handshake
  assign rd_take = i_axi.arvalid && !rvalid_reg;
  assign rd_cfg = !i_axi.araddr[7] && (i_axi.araddr[6:5] != 2'h0);
  assign rd_idx = i_axi.araddr[6:2] - 5'd8;
  assign rd_hit = rd_cfg || (i_axi.araddr[1:0] == 2'h0 &&
                  i_axi.araddr <= CLB_REG_GATES);
  assign rd_word =
    rd_cfg ? cfg_reg[rd_idx] :
    (i_axi.araddr == CLB_REG_CTRL) ? {30'h0, ctrl_reg} :
    (i_axi.araddr == CLB_REG_STATUS) ?
      {30'h0, state_reg == CLB_ST_FIRST, state_reg != CLB_ST_STOP} :
    (i_axi.araddr == CLB_REG_CURSOR) ? {28'h0, cursor_reg} :
    (i_axi.araddr == CLB_REG_FLAGS) ? {8'h0, flag_reg} :
    (i_axi.araddr == CLB_REG_OUTS) ? {blank_reg, dout_reg} :
    (i_axi.araddr == CLB_REG_GATES) ? {24'h0, gate_reg} :
    32'h0;

  // Handshake outputs
  assign o_axi.awready = !aw_have;
  assign o_axi.wready = !w_have;
  assign o_axi.bvalid = bvalid_reg;
  assign o_axi.bresp = bresp_reg;
  assign o_axi.arready = !rvalid_reg;
  assign o_axi.rvalid = rvalid_reg;
  assign o_axi.rdata = rdata_reg;
  assign o_axi.rresp = rresp_reg;

  // Write channel capture and response
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= CLB_RESP_OKAY;
    end else begin
      if (i_axi.awvalid && !aw_have) begin
        aw_have <= 1'b1;
        aw_addr <= i_axi.awaddr;
      end else if (do_wr) begin
        aw_have <= 1'b0;
      end
      if (i_axi.wvalid && !w_have) begin
        w_have <= 1'b1;
        w_data <= i_axi.wdata;
        w_strb <= i_axi.wstrb;
      end else if (do_wr) begin
        w_have <= 1'b0;
      end
      if (do_wr) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? CLB_RESP_OKAY : CLB_RESP_SLVERR;
      end else if (i_axi.bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Software registers; status and shift bits have no write path
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= 2'h0;
      cursor_reg <= 4'h0;
      for (int n = 0; n < CLB_NCFG; n++) begin
        cfg_reg[n] <= (n < CLB_NGATE) ? CLB_GCFG_RST : 32'h0;
      end
    end else if (do_wr) begin
      if (aw_addr == CLB_REG_CTRL && w_strb[0]) begin
        ctrl_reg <= w_data[1:0];
      end
      if (aw_addr == CLB_REG_CURSOR && w_strb[0]) begin
        cursor_reg <= w_data[3:0];
      end
      for (int b = 0; b < 4; b++) begin
        if (wr_cfg && w_strb[b]) begin
          cfg_reg[wr_idx][8*b +: 8] <= w_data[8*b +: 8];
        end
      end
    end
  end

  // Read response
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= CLB_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? CLB_RESP_OKAY : CLB_RESP_SLVERR;
    end else if (i_axi.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

/* sim/clb_field.sv */
`timescale 1ns/1ps
// ----
// Field terminals and shift function
// ----
module clb_field (
  input wire logic i_clk,
  input wire logic [clb_pkg::CLB_NDIN-1:0] i_din_set,
  input wire logic [clb_pkg::CLB_NSHIFT-1:0] i_shift_set,
  output logic [clb_pkg::CLB_NDIN-1:0] o_din,
  output logic [clb_pkg::CLB_NSHIFT-1:0] o_shift,
  output clb_pkg::clb_ana_t [clb_pkg::CLB_NAIN-1:0] o_ain
);
  import clb_pkg::*;
  // Terminals change just after an edge, input 1 on bit 0
  always_ff @(posedge i_clk) begin
    o_din <= i_din_set;
    o_shift <= i_shift_set;
  end
  // Each analog lane carries its own level
  always_comb begin
    for (int k = 0; k < CLB_NAIN; k++) begin
      o_ain[k] = clb_ana_t'(k * 64 + 5);
    end
  end
endmodule

/* sim/clb_monitor.sv */
`timescale 1ns/1ps
// ----
// Port checks
// ----
module clb_monitor #(
  parameter int CYCLE_CLKS = clb_pkg::CLB_CYCLE_CLKS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire clb_pkg::clb_axi_req_t i_axi,
  input wire clb_pkg::clb_axi_rsp_t o_axi,
  input wire logic [clb_pkg::CLB_NDIN-1:0] i_din,
  input wire logic [clb_pkg::CLB_NSHIFT-1:0] i_shift,
  input wire clb_pkg::clb_ana_t [clb_pkg::CLB_NAIN-1:0] i_ain,
  input wire logic [clb_pkg::CLB_NDOUT-1:0] o_dout,
  input wire clb_pkg::clb_ana_t [clb_pkg::CLB_NAQ-1:0] o_aq,
  input wire logic o_startup
);
  import clb_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Bus answers stand until taken
  bresp_hold_a: assert property (o_axi.bvalid && !i_axi.bready |=>
    o_axi.bvalid && $stable(o_axi.bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (o_axi.rvalid && !i_axi.rready |=>
    o_axi.rvalid && $stable(o_axi.rdata)) else $error("rdata dropped");
  rresp_hold_a: assert property (o_axi.rvalid && !i_axi.rready |=>
    $stable(o_axi.rresp)) else $error("rresp dropped");
  read_answer_a: assert property (i_axi.arvalid && o_axi.arready |=>
    o_axi.rvalid) else $error("read answer late");
  write_answer_a: assert property (i_axi.awvalid && o_axi.awready &&
    i_axi.wvalid && o_axi.wready |-> ##[1:2] o_axi.bvalid)
    else $error("write answer late");
  read_unmapped_a: assert property (i_axi.arvalid && o_axi.arready &&
    i_axi.araddr == 8'h18 |=> o_axi.rresp == CLB_RESP_SLVERR &&
    o_axi.rdata == 32'h0) else $error("unmapped read not refused");
  // Results hold for a whole program cycle of four clocks
  dout_hold_a: assert property (
    $changed(o_dout) |=> $stable(o_dout) [*3])
    else $error("outputs changed within a cycle");
  startup_hold_a: assert property (
    $changed(o_startup) |=> $stable(o_startup) [*3])
    else $error("startup flag changed within a cycle");
  aq_hold_a: assert property (
    $changed(o_aq) |=> $stable(o_aq) [*3])
    else $error("analog outputs changed within a cycle");
  startup_reset_a: assert property (
    $fell(i_rst) |-> o_startup) else $error("startup flag low at start");
endmodule
bind clb_top clb_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) u_clb_monitor (
  .i_clk(i_clk), .i_rst(i_rst), .i_axi(i_axi), .o_axi(o_axi),
  .i_din(i_din), .i_shift(i_shift), .i_ain(i_ain), .o_dout(o_dout),
  .o_aq(o_aq), .o_startup(o_startup));

/* sim/clb_top_tb.sv */
`timescale 1ns/1ps
module clb_top_tb;
  import clb_pkg::*;
  localparam int CC = 4;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  clb_axi_req_t req = '0;
  clb_axi_rsp_t rsp;
  logic [CLB_NDIN-1:0] din_set = '0;
  logic [CLB_NSHIFT-1:0] shift_set = '0;
  logic [CLB_NDIN-1:0] din;
  logic [CLB_NSHIFT-1:0] shift;
  clb_ana_t [CLB_NAIN-1:0] ain;
  logic [CLB_NDOUT-1:0] dout;
  clb_ana_t [CLB_NAQ-1:0] aq;
  logic startup;
  logic [31:0] rd;
  logic [1:0] rr;
  int n_fail = 0;
  int compares = 0;
  int ticks = 0;
  // ----
  // Clock, design and field side
  // ----
  always #2 i_clk = ~i_clk;
  clb_top #(.CYCLE_CLKS(CC)) u_clb_top (.i_clk(i_clk), .i_rst(i_rst),
    .i_axi(req), .o_axi(rsp), .i_din(din), .i_shift(shift), .i_ain(ain),
    .o_dout(dout), .o_aq(aq), .o_startup(startup));
  clb_field u_clb_field (.i_clk(i_clk), .i_din_set(din_set),
    .i_shift_set(shift_set), .o_din(din), .o_shift(shift), .o_ain(ain));
  // Hang guard
  always @(posedge i_clk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      n_fail = n_fail + 1;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus master: hold each channel until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    do begin
      @(posedge i_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    // Answer seen with bready low, so it must stand; take it next edge
    req.bready <= 1'b1;
    @(posedge i_clk);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rdw(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge i_clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do begin
      @(posedge i_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    // Answer seen with rready low, so it must stand; take it next edge
    req.rready <= 1'b1;
    @(posedge i_clk);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic settle();
    repeat (6 * CC) @(posedge i_clk);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    chk("startup at reset", 1, startup);
    chk("dout at reset", 0, dout);
    rdw(CLB_REG_CFG, rd, rr);
    chk("gate cfg reset", CLB_GCFG_RST, rd);
  endtask
  task automatic t_unmapped();
    rdw(8'h18, rd, rr);
    chk("unmapped rresp", CLB_RESP_SLVERR, rr);
    wr(8'h18, 32'hFFFFFFFF, rr);
    chk("unmapped bresp", CLB_RESP_SLVERR, rr);
  endtask
  task automatic t_setup();
    logic [7:0] a [11] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h40, 8'h44,
      8'h50, 8'h60, 8'h78, 8'h7C, 8'h08};
    logic [31:0] d [11] = '{32'h001440C2, 32'h301440C2, 32'h101440C2,
      32'h01FFF042, 32'h12393837, 32'h01322A19, 32'h00000001,
      32'h00000002, 32'h00000003, 32'h00000082, 32'h00000001};
    for (int i = 0; i < 11; i++) begin
      wr(a[i], d[i], rr);
      chk("cfg bresp", CLB_RESP_OKAY, rr);
    end
    wr(CLB_REG_CTRL, 32'h1, rr);
    chk("startup first cycle", 1, startup);
    settle();
    chk("startup cleared", 0, startup);
    rdw(CLB_REG_STATUS, rd, rr);
    chk("status", 32'h1, rd);
    wr(8'h64, 32'h01000000, rr);
    settle();
    chk("startup as flag", 1, startup);
    chk("analog out 1", 133, aq[0]);
    chk("analog out 2", 197, aq[1]);
  endtask
  task automatic t_truth();
    logic [3:0] v;
    logic [15:0] ex;
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      din_set <= {12'h000, v};
      settle();
      rdw(CLB_REG_GATES, rd, rr);
      // Gates 5 to 8 are left all open, so they read as 1
      chk("gates", {24'h0, 4'hF, ~v[0], 1'b0, ~&v, &v}, rd);
      ex = {8'h00, 4'hD, v[0], ~v[0], 1'b0, ~&v};
      chk("dout", ex, dout);
    end
  endtask
  task automatic t_edge();
    int n;
    din_set <= 16'h0007;
    settle();
    din_set <= 16'h000F;
    n = 0;
    repeat (8 * CC) begin
      @(posedge i_clk);
      if (dout[1] === 1'b1) n++;
    end
    chk("edge and width", CC, n);
  endtask
  task automatic t_shift();
    shift_set <= 8'h01;
    wr(CLB_REG_FLAGS, 32'h00FFFFFF, rr);
    chk("flags write bresp", CLB_RESP_OKAY, rr);
    settle();
    chk("shift bit", 1, dout[5]);
    rdw(CLB_REG_FLAGS, rd, rr);
    chk("flags kept", 32'h81, rd);
    rdw(CLB_REG_OUTS, rd, rr);
    chk("blank outputs", 32'h00000001, rd[31:16]);
  endtask
  // Pins 7 and 8 switch from digital to analog use
  task automatic t_dual();
    din_set <= 16'h00C1;
    wr(8'h60, 32'h00000802, rr);
    wr(8'h7C, 32'h00000010, rr);
    settle();
    chk("lane 0 while digital", 32'h0, aq[0]);
    rdw(CLB_REG_FLAGS, rd, rr);
    chk("pin 7 digital", 32'h83, rd);
    wr(CLB_REG_CTRL, 32'h3, rr);
    settle();
    chk("lane 0 analog", 32'd5, aq[0]);
    chk("lane 1 analog", 32'd69, aq[1]);
    rdw(CLB_REG_FLAGS, rd, rr);
    chk("pin 7 analog", 32'h81, rd);
  endtask
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset();
    t_unmapped();
    t_setup();
    t_truth();
    t_edge();
    t_shift();
    t_dual();
    summarize();
  end
endmodule
